// ---- rtl/emp_pkg.sv ----
package emp_pkg;
  localparam int unsigned ROW_NUM     = 128;
  localparam int unsigned ROW_W       = 16;
  localparam int unsigned ADDR_W      = 11;
  localparam int unsigned PAGE_W      = 2;
  localparam int unsigned ASPECT_W    = 3;
  localparam logic [2:0]  ASPECT_MAX  = 3'h4;
  localparam logic [15:0] DATA_RST    = 16'h0000;

  // Aspect codes: width is 16 >> code, depth is 128 << code
  localparam logic [2:0] ASP_128X16  = 3'h0;
  localparam logic [2:0] ASP_256X8   = 3'h1;
  localparam logic [2:0] ASP_512X4   = 3'h2;
  localparam logic [2:0] ASP_1024X2  = 3'h3;
  localparam logic [2:0] ASP_2048X1  = 3'h4;

  localparam int unsigned MC_TYPE_W  = 3;
  localparam logic [2:0] MC_D        = 3'h0;
  localparam logic [2:0] MC_T        = 3'h1;
  localparam logic [2:0] MC_JK       = 3'h2;
  localparam logic [2:0] MC_SR       = 3'h3;
  localparam logic [2:0] MC_BYPASS   = 3'h4;
endpackage : emp_pkg

// ---- rtl/emp_block.sv ----
// Contract
// [R1] Write strobe made internally, timed by clock
// [R2] Aspect 128x16 through 2048x1 selectable
// [R3] Blocks ganged side by side share address
// [R4] Page decoder enables shared column driver
// [R5] Only selected page drives, never floats
// [R6] Input registers and output registers separately clocked; here both on clk_sys, separately enabled
// [R7] Independent enable and clear, input and output
// [R8] All registers clearable local, global, reset
// [R9] Single-port mode supported
// [R10] Macrocell D, T, JK, SR or bypass
// [R11] Macrocell picks one of two clocks
// [R12] Each block clock has its enable
// [R13] Both edges consume both block clocks; here falling-edge cells use clock 1, others the one cfg_mc_clk picks
// [R14] Single-port shares address, no simultaneous access
module emp_block #(
  parameter int unsigned MC_NUM = 16
) (
  input  wire logic                                clk_sys,
  input  wire logic                                rst,
  input  wire logic [emp_pkg::ASPECT_W-1:0]        cfg_aspect,
  input  wire logic                                cfg_single_port,
  input  wire logic                                cfg_deep,
  input  wire logic [emp_pkg::PAGE_W-1:0]          cfg_page,
  input  wire logic                                in_ena,
  input  wire logic                                out_ena,
  input  wire logic                                in_clr,
  input  wire logic                                out_clr,
  input  wire logic                                glb_clr,
  input  wire logic                                wr_strobe,
  input  wire logic                                read_strobe,
  input  wire logic [emp_pkg::ADDR_W-1:0]          wr_addr,
  input  wire logic [emp_pkg::ADDR_W-1:0]          rd_addr,
  input  wire logic [emp_pkg::PAGE_W-1:0]          rd_page,
  input  wire logic [emp_pkg::ROW_W-1:0]           wr_data,
  output logic      [emp_pkg::ROW_W-1:0]           col_line_o,
  output logic                                     col_line_oe_n,
  input  wire logic [1:0]                          blk_clk_tick,
  input  wire logic [1:0]                          blk_clk_en,
  input  wire logic                                mc_clr,
  input  wire logic [MC_NUM*emp_pkg::MC_TYPE_W-1:0] cfg_mc_type,
  input  wire logic [MC_NUM-1:0]                   cfg_mc_clk,
  input  wire logic [MC_NUM-1:0]                   cfg_mc_fall,
  input  wire logic [MC_NUM-1:0]                   pt_a,
  input  wire logic [MC_NUM-1:0]                   pt_b,
  output logic      [MC_NUM-1:0]                   mc_out
);
  import emp_pkg::*;

  if (MC_NUM < 1 || MC_NUM > 64) begin : g_chk
    $error("emp_block: MC_NUM out of range");
  end

  // Row slicing below is hard-wired to 16-bit rows over 11 address bits
  if (ROW_NUM * ROW_W != (1 << ADDR_W)) begin : g_geo
    $error("emp_block: memory geometry does not match addressing");
  end

  logic [ROW_W-1:0] mem [0:ROW_NUM-1];

  // Input side registers
  logic [ROW_W-1:0]  wd_r, wd_nxt;
  logic [ADDR_W-1:0] wa_r, wa_nxt, ra_r, ra_nxt;
  logic [PAGE_W-1:0] pg_r, pg_nxt;
  logic              we_r, we_nxt, re_r, re_nxt;
  // Output side and macrocell registers
  logic [ROW_W-1:0]  do_r, do_nxt;
  logic              oe_n_r, oe_n_nxt;
  logic [MC_NUM-1:0] mc_r, mc_nxt;

  logic              clr_all;
  logic [ROW_W-1:0]  wmask, wrow, rword;
  logic [6:0]        wrow_idx, rrow_idx;
  logic [3:0]        wcol, rcol;
  logic [ADDR_W-1:0] wbit, rbit, rd_src;
  logic [ROW_W-1:0]  wmask_w;

  // [R8] Reset or global clear
  assign clr_all = rst | glb_clr;

  always_comb begin
    wd_nxt = wd_r;
    wa_nxt = wa_r;
    ra_nxt = ra_r;
    pg_nxt = pg_r;
    we_nxt = we_r;
    re_nxt = re_r;
    // [R14] Shared address single port
    rd_src = cfg_single_port ? wr_addr : rd_addr;
    // [R7] Input side enable
    if (in_ena) begin
      // [R6] Inputs on clk_sys, loaded under in_ena
      wd_nxt = wr_data;
      wa_nxt = wr_addr;
      ra_nxt = rd_src;
      pg_nxt = rd_page;
      we_nxt = wr_strobe;
      // [R9] Write wins, no read
      re_nxt = read_strobe & ~(cfg_single_port & wr_strobe);
    end
    // [R7] Input side clear
    if (in_clr | clr_all) begin
      wd_nxt = DATA_RST;
      wa_nxt = '0;
      ra_nxt = '0;
      pg_nxt = '0;
      we_nxt = 1'b0;
      re_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    wd_r <= wd_nxt;
    wa_r <= wa_nxt;
    ra_r <= ra_nxt;
    pg_r <= pg_nxt;
    we_r <= we_nxt;
    re_r <= re_nxt;
  end

  // [R2] Aspect maps word to bit slice
  always_comb begin
    wbit     = ADDR_W'(wa_r) << (ASPECT_MAX - cfg_aspect);
    rbit     = ADDR_W'(ra_r) << (ASPECT_MAX - cfg_aspect);
    wrow_idx = wbit[10:4];
    wcol     = wbit[3:0];
    rrow_idx = rbit[10:4];
    rcol     = rbit[3:0];
    // Slice width is 16 >> aspect, so the mask holds that many ones
    wmask_w  = ROW_W'((17'h0_0001 << (5'h10 >> cfg_aspect)) - 17'h0_0001);
    wmask    = wmask_w << wcol;
    wrow     = (mem[wrow_idx] & ~wmask) | ((wd_r << wcol) & wmask);
    rword    = (mem[rrow_idx] >> rcol) & wmask_w;
  end

  // [R1] Self-timed write from registered strobe
  always_ff @(posedge clk_sys) begin
    if (we_r) begin
      mem[wrow_idx] <= wrow;
    end
  end

  always_comb begin
    do_nxt   = do_r;
    oe_n_nxt = oe_n_r;
    // [R7] Output side enable
    if (out_ena) begin
      // [R6] Data out on clk_sys, loaded under out_ena
      if (re_r) begin
        do_nxt = rword;
      end
      // [R4] Page decoder drives column
      // [R3] Without paging every block drives
      // [R5] Exactly one page owner
      oe_n_nxt = cfg_deep & (pg_r != cfg_page);
    end
    // [R7] Output side clear
    if (out_clr | clr_all) begin
      do_nxt   = DATA_RST;
      oe_n_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    do_r   <= do_nxt;
    oe_n_r <= oe_n_nxt;
  end

  assign col_line_o    = do_r;
  assign col_line_oe_n = oe_n_r;

  // Product-term macrocells
  for (genvar i = 0; i < MC_NUM; i++) begin : g_mc
    logic [MC_TYPE_W-1:0] typ;
    logic                 sel, fire, q;
    assign typ = cfg_mc_type[i*MC_TYPE_W +: MC_TYPE_W];
    // [R13] Falling edge uses second clock
    // [R11] One of two block clocks
    assign sel = cfg_mc_fall[i] | cfg_mc_clk[i];
    // [R12] Clock gated by own enable
    assign fire = blk_clk_tick[sel] & blk_clk_en[sel];
    always_comb begin
      q = mc_r[i];
      // [R10] Register type select
      case (typ)
        MC_D:      q = fire ? pt_a[i] : mc_r[i];
        MC_T:      q = fire ? (mc_r[i] ^ pt_a[i]) : mc_r[i];
        MC_JK: begin
          if (fire) begin
            case ({pt_a[i], pt_b[i]})
              2'h1:    q = 1'b0;
              2'h2:    q = 1'b1;
              2'h3:    q = ~mc_r[i];
              default: q = mc_r[i];
            endcase
          end
        end
        MC_SR: begin
          if (fire && pt_b[i]) begin
            q = 1'b0;
          end else if (fire && pt_a[i]) begin
            q = 1'b1;
          end
        end
        MC_BYPASS: q = pt_a[i];
        default:   q = mc_r[i];
      endcase
      // [R8] Macrocell clear
      if (mc_clr | clr_all) begin
        q = 1'b0;
      end
    end
    assign mc_nxt[i] = q;
  end

  always_ff @(posedge clk_sys) begin
    mc_r <= mc_nxt;
  end

  assign mc_out = mc_r;
endmodule : emp_block

// ---- test/emp_block_monitor.sv ----
module emp_block_monitor #(
  parameter int unsigned MC_NUM = 16
) (
  input logic clk_sys,
  input logic rst,
  input logic in_ena,
  input logic in_clr,
  input logic cfg_single_port,
  input logic cfg_deep,
  input logic [emp_pkg::PAGE_W-1:0] cfg_page,
  input logic [emp_pkg::PAGE_W-1:0] rd_page,
  input logic wr_strobe,
  input logic out_ena,
  input logic out_clr,
  input logic glb_clr,
  input logic [emp_pkg::ROW_W-1:0] col_line_o,
  input logic col_line_oe_n,
  input logic [1:0] blk_clk_tick,
  input logic [1:0] blk_clk_en,
  input logic mc_clr,
  input logic [MC_NUM*emp_pkg::MC_TYPE_W-1:0] cfg_mc_type,
  input logic [MC_NUM-1:0] cfg_mc_clk,
  input logic [MC_NUM-1:0] cfg_mc_fall,
  input logic [MC_NUM-1:0] pt_a,
  input logic [MC_NUM-1:0] mc_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import emp_pkg::*;
  logic [2:0] t0;
  logic s0, f0, c0;
  assign t0 = cfg_mc_type[2:0];
  // Falling-edge cells are forced onto clock 1
  assign s0 = cfg_mc_clk[0] | cfg_mc_fall[0];
  assign f0 = blk_clk_tick[s0] & blk_clk_en[s0];
  assign c0 = !mc_clr & !glb_clr;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Page taken on the input side, then moved to the output side
  sequence s_page_taken;
    in_ena && !in_clr && !glb_clr ##1 out_ena && !out_clr && !glb_clr;
  endsequence
  // Single-port write with any read in the same cycle
  sequence s_write_wins;
    cfg_single_port && in_ena && wr_strobe && !in_clr && !glb_clr
      ##1 !out_clr && !glb_clr;
  endsequence
  a_clr_all: assert property (glb_clr |=>
    col_line_oe_n && mc_out == '0) else $error("clear");
  a_mc_clr: assert property (mc_clr |=> mc_out == '0)
    else $error("cell clear");
  a_out_clr: assert property (out_clr |=>
    col_line_oe_n && col_line_o == DATA_RST) else $error("out clear");
  a_out_hold: assert property (!out_ena && !out_clr && !glb_clr |=>
    $stable(col_line_o) && $stable(col_line_oe_n)) else $error("hold");
  a_mc_bypass: assert property (c0 && t0 == MC_BYPASS |=>
    mc_out[0] == $past(pt_a[0])) else $error("bypass");
  a_mc_d_load: assert property (c0 && f0 && t0 == MC_D |=>
    mc_out[0] == $past(pt_a[0])) else $error("d load");
  a_mc_toggle: assert property (c0 && f0 && t0 == MC_T |=>
    mc_out[0] == ($past(mc_out[0]) ^ $past(pt_a[0]))) else $error("t");
  a_mc_gate: assert property (c0 && !f0 && t0 != MC_BYPASS |=>
    $stable(mc_out[0])) else $error("gate");
  a_page_drive: assert property (s_page_taken |=>
    col_line_oe_n ==
      ($past(cfg_deep) && $past(rd_page, 2) != $past(cfg_page)))
    else $error("page drive");
  a_write_wins: assert property (s_write_wins |=>
    $stable(col_line_o)) else $error("single port read not dropped");
endmodule : emp_block_monitor
bind emp_block emp_block_monitor #(.MC_NUM(MC_NUM)) i_mon (.*);

// ---- test/emp_fabric.sv ----
module emp_fabric (
  input  wire logic                  clk_sys,
  output logic                       wr_strobe = 1'h0,
  output logic                       read_strobe = 1'h0,
  output logic [emp_pkg::ADDR_W-1:0] wr_addr = '0,
  output logic [emp_pkg::ADDR_W-1:0] rd_addr = '0,
  output logic [emp_pkg::PAGE_W-1:0] rd_page = '0,
  output logic [emp_pkg::ROW_W-1:0]  wr_data = '0
);
  timeunit 1ns;
  timeprecision 1ns;
  import emp_pkg::*;
  // One request per edge; no strobe timing of our own is needed
  task automatic put(input logic w, r, input int a, d, p);
    @(posedge clk_sys);
    {wr_strobe, read_strobe} <= {w, r};
    {wr_addr, rd_addr} <= {2{ADDR_W'(a)}};
    rd_page <= PAGE_W'(p);
    wr_data <= ROW_W'(d);
  endtask : put
endmodule : emp_fabric

// ---- test/emp_block_tb.sv ----
module emp_block_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'h0, rst = 1'h1, in_ena = 1'h1, out_ena = 1'h1;
  logic in_clr = 1'h0, out_clr = 1'h0, glb_clr = 1'h0, mc_clr = 1'h0;
  logic cfg_single_port = 1'h0, cfg_deep = 1'h0, col_line_oe_n;
  logic wr_strobe, read_strobe;
  logic [1:0] cfg_page = 2'h0, rd_page, blk_clk_tick, blk_clk_en;
  logic [2:0] cfg_aspect = 3'h0;
  logic [10:0] wr_addr, rd_addr;
  logic [15:0] wr_data, col_line_o, mc_out, e;
  logic [15:0] pt_a, pt_b, cfg_mc_clk, cfg_mc_fall;
  logic [47:0] cfg_mc_type;
  logic [2047:0] mdl;
  int miscompares = 0, n_compared = 0, w, m, a, p, r;
  int k;
  logic [15:0] q_mdl = 16'h0000;
  logic [2:0] t;
  logic f;
  always #20 clk_sys = ~clk_sys;
  emp_fabric i_emp_fabric (.*);
  emp_block i_emp_block (.*);
  task automatic check(input logic [15:0] g, x);
    n_compared++;
    if (g !== x) begin
      miscompares++;
      $display("Error %0t: got %h want %h", $time, g, x);
    end
  endtask : check
  task automatic finish_test();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    {blk_clk_tick, blk_clk_en, pt_a, pt_b, cfg_mc_type} = '0;
    {cfg_mc_clk, cfg_mc_fall} = '0;
    void'($urandom(32'h8d08));
    repeat (12) @(posedge clk_sys);
    rst <= 1'h0;
    // Linear bit model: narrow words pack LSB-first
    for (int s = 0; s < 5; s++) begin
      @(posedge clk_sys);
      {cfg_aspect, cfg_deep, cfg_page} <= {3'(s), s[0], 2'(s)};
      w = 16 >> s;
      m = (1 << w) - 1;
      repeat (6) begin
        a = $urandom % (128 << s);
        r = $urandom & m;
        p = $urandom % 4;
        mdl = mdl & ~(2048'(m) << a * w) | 2048'(r) << a * w;
        i_emp_fabric.put(1'h1, 1'h0, a, r, p);
        i_emp_fabric.put(1'h0, 1'h0, $urandom, $urandom, p);
        i_emp_fabric.put(1'h0, 1'h1, a, $urandom, p);
        i_emp_fabric.put(1'h0, 1'h0, $urandom, $urandom, p);
        @(posedge clk_sys);
        #1;
        e = 16'(mdl >> a * w) & 16'(m);
        check(16'(col_line_oe_n), 16'(s[0] && p != s % 4));
        if (col_line_oe_n === 1'h0) check(col_line_o, e);
      end
    end
    // Single port: a write in the same cycle drops the read
    @(posedge clk_sys);
    {cfg_aspect, cfg_deep, cfg_single_port} <= {3'h0, 1'h0, 1'h1};
    a = $urandom % 128;
    r = $urandom & 16'hffff;
    i_emp_fabric.put(1'h1, 1'h1, a, r, 0);
    i_emp_fabric.put(1'h0, 1'h0, a, 0, 0);
    i_emp_fabric.put(1'h0, 1'h0, a, 0, 0);
    @(posedge clk_sys);
    #1;
    check(col_line_o, e);
    i_emp_fabric.put(1'h0, 1'h1, a, 0, 0);
    i_emp_fabric.put(1'h0, 1'h0, a, 0, 0);
    @(posedge clk_sys);
    #1;
    check(col_line_o, 16'(r));
    repeat (300) begin
      @(posedge clk_sys);
      // Inputs still stand as the design sampled them at this edge
      for (int i = 0; i < 16; i++) begin
        t = cfg_mc_type[3 * i +: 3];
        k = int'(cfg_mc_fall[i] | cfg_mc_clk[i]);
        f = blk_clk_tick[k] & blk_clk_en[k];
        case (t)
          emp_pkg::MC_D:      q_mdl[i] = f ? pt_a[i] : q_mdl[i];
          emp_pkg::MC_T:      q_mdl[i] = q_mdl[i] ^ (f & pt_a[i]);
          emp_pkg::MC_JK:     q_mdl[i] = f ? (pt_a[i] & ~q_mdl[i]) |
                                             (~pt_b[i] & q_mdl[i])
                                           : q_mdl[i];
          emp_pkg::MC_SR:     q_mdl[i] = f ? ~pt_b[i] & (pt_a[i] | q_mdl[i])
                                           : q_mdl[i];
          emp_pkg::MC_BYPASS: q_mdl[i] = pt_a[i];
          default:            q_mdl[i] = q_mdl[i];
        endcase
        if (mc_clr || glb_clr)
          q_mdl[i] = 1'h0;
      end
      r = $urandom;
      cfg_mc_type <= {16{3'($urandom % 5)}};
      {pt_a, pt_b, cfg_mc_clk, cfg_mc_fall} <= {$urandom, $urandom};
      {blk_clk_tick, blk_clk_en, in_ena, out_ena, cfg_single_port} <= r[6:0];
      {mc_clr, glb_clr, in_clr, out_clr} <= 4'(r[14:11] == 0) << r[17:16];
      #1;
      check(mc_out, q_mdl);
    end
    finish_test();
  end
endmodule : emp_block_tb
